/* File: design/irqpe_pkg.sv */
// Package for the group-two pending register and group-zero priority enables.
// Assumes a 32-bit APB slave port and one core clock domain.

package irqpe_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [29:0] IDX_G0_PRIO_HIGH = 30'h00FFE032;
  localparam logic [29:0] IDX_G0_PRIO_LOW  = 30'h00FFE033;
  localparam logic [29:0] IDX_G2_PENDING   = 30'h00FFE038;
  localparam logic [29:0] IDX_G2_SET       = 30'h00FFE039;
  localparam logic [29:0] IDX_G2_MASK      = 30'h00FFE03C;
  localparam logic [29:0] IDX_CTRL         = 30'h00FFE03D;

  // ---------------------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_G0_PRIO  = 8'h00;
  localparam logic [7:0] RST_G2_PEND  = 8'h00;
  localparam logic [7:0] RST_G2_MASK  = 8'h00;
  localparam logic       RST_GLOB_EN  = 1'b0;
  localparam int         CTRL_GLOB_EN = 0;

  // Group-two pending bit positions
  localparam int BIT_PWM_TIMER  = 7;
  localparam int BIT_UART1_RX   = 6;
  localparam int BIT_UART1_TX   = 5;
  localparam int BIT_PWM_FAULT  = 4;
  localparam int BIT_PORTC_TOP  = 3;

  // Group-zero source bit positions
  localparam int BIT_TIMER2  = 7;
  localparam int BIT_TIMER1  = 6;
  localparam int BIT_TIMER0  = 5;
  localparam int BIT_U0_RX   = 4;
  localparam int BIT_U0_TX   = 3;
  localparam int BIT_TWOWIRE = 2;
  localparam int BIT_SPI     = 1;
  localparam int BIT_ADC     = 0;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_OFF  = 2'h0,
    LVL_LOW  = 2'h1,
    LVL_NOM  = 2'h2,
    LVL_HIGH = 2'h3
  } irqpe_level_e;

  // Priority level of each group-zero source
  typedef struct packed {
    irqpe_level_e timer2;
    irqpe_level_e timer1;
    irqpe_level_e timer0;
    irqpe_level_e uart0Rx;
    irqpe_level_e uart0Tx;
    irqpe_level_e twoWire;
    irqpe_level_e serialPeriph;
    irqpe_level_e converter;
  } irqpe_prio_s;

  // Group-two request sources
  typedef struct packed {
    logic       pwmTimer;
    logic       uart1Rx;
    logic       uart1Tx;
    logic       pwmFault;
    logic [3:0] portcOrDma;
  } irqpe_req_s;

endpackage : irqpe_pkg

/* File: design/irqpe_top.sv */
// Group-two interrupt pending register with set register, group-zero
// two-bit priority enables, and the interrupt request toward the CPU core.
// Assumes an APB master on core_clk and requests synchronous to core_clk.
// Mask and control registers sit three and four indices above the set register in the map.
// A pending read shows requests that arrive up to its setup cycle.
// cpuIrq follows the next pending value, so it rises with the pending bit.
//
// Contract
// (R1) A peripheral request sets its pending bit, held until cleared.
// (R2) With global enable on, pending unmasked requests interrupt the CPU.
// (R3) With global enable off, no CPU interrupt; pending stays readable.
// (R4) Writing one to a pending bit clears it; zero leaves it.
// (R5) Write-only set register after pending; ones set bits; reads zero.
// (R6) Pending bits: PWM timer 7, UART1 rx 6, UART1 tx 5, PWM fault 4.
// (R7) Pending bits 3..0 carry port C pin x or DMA channel x.
// (R8) High/low enable bits code priority: off, low, nominal, high.
// (R9) Enable-high register read/write, timer2 down to converter in bits 7..0.
// (R10) Enable-low register read/write, same ordering, supplies low bit.
// (R11) Pending bits set regardless of enables; enables only gate forwarding.
// (R12) Enable-high bit 6 belongs to timer 1.

`timescale 1ns/1ps

module irqpe_top
  import irqpe_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral requests, one cycle high or level
  input  wire irqpe_req_s  grp2Req,
  // Toward CPU core and arbitration
  output logic             cpuIrq,
  output logic [7:0]       grp2Pending,
  output irqpe_prio_s      grp0Prio
);

  // ---------------------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync_r;

  // Asynchronous assert, two-flop release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Byte address of a register index
  function automatic logic [31:0] regAddr(input logic [29:0] idx);
    regAddr = {idx, 2'b00};
  endfunction

  // Two enable bits into a priority level
  function automatic irqpe_level_e toLevel(input logic hi, input logic lo);
    toLevel = irqpe_level_e'({hi, lo});
  endfunction

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic       setupPhase;
  logic       accessPhase;
  logic       wrAccess;
  logic       hitPrioHigh;
  logic       hitPrioLow;
  logic       hitPending;
  logic       hitSet;
  logic       hitMask;
  logic       hitCtrl;
  logic       hitAny;
  logic [7:0] wrByte;

  // Address match and phase detection
  always_comb begin
    setupPhase  = psel && !penable;
    accessPhase = psel && penable;
    wrAccess    = accessPhase && pwrite && pstrb[0];
    hitPrioHigh = paddr == regAddr(IDX_G0_PRIO_HIGH);
    hitPrioLow  = paddr == regAddr(IDX_G0_PRIO_LOW);
    hitPending  = paddr == regAddr(IDX_G2_PENDING);
    hitSet      = paddr == regAddr(IDX_G2_SET);
    hitMask     = paddr == regAddr(IDX_G2_MASK);
    hitCtrl     = paddr == regAddr(IDX_CTRL);
    hitAny      = hitPrioHigh || hitPrioLow || hitPending || hitSet || hitMask || hitCtrl;
    wrByte      = pwdata[7:0];
  end

  // No wait states, so every access phase lasts one cycle
  // Zero wait state; data is prepared in the setup cycle
  assign pready = 1'b1;

  // ---------------------------------------------------------------------------
  // Group-zero priority enables
  // ---------------------------------------------------------------------------
  logic [7:0] prioHigh_r;
  logic [7:0] prioLow_r;

  // High bits, plain read/write
  always_ff @(posedge core_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      prioHigh_r <= RST_G0_PRIO;
    end else if (wrAccess && hitPrioHigh) begin
      prioHigh_r <= wrByte; // see (R9)
    end
  end

  // Low bits, plain read/write
  always_ff @(posedge core_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      prioLow_r <= RST_G0_PRIO;
    end else if (wrAccess && hitPrioLow) begin
      prioLow_r <= wrByte; // see (R10)
    end
  end

  // Per-source level, same ordering in both registers
  always_comb begin
    grp0Prio.timer2       = toLevel(prioHigh_r[BIT_TIMER2], prioLow_r[BIT_TIMER2]); // see (R8)
    grp0Prio.timer1       = toLevel(prioHigh_r[BIT_TIMER1], prioLow_r[BIT_TIMER1]); // see (R12)
    grp0Prio.timer0       = toLevel(prioHigh_r[BIT_TIMER0], prioLow_r[BIT_TIMER0]);
    grp0Prio.uart0Rx      = toLevel(prioHigh_r[BIT_U0_RX], prioLow_r[BIT_U0_RX]);
    grp0Prio.uart0Tx      = toLevel(prioHigh_r[BIT_U0_TX], prioLow_r[BIT_U0_TX]);
    grp0Prio.twoWire      = toLevel(prioHigh_r[BIT_TWOWIRE], prioLow_r[BIT_TWOWIRE]);
    grp0Prio.serialPeriph = toLevel(prioHigh_r[BIT_SPI], prioLow_r[BIT_SPI]);
    grp0Prio.converter    = toLevel(prioHigh_r[BIT_ADC], prioLow_r[BIT_ADC]); // see (R10)
  end

  // ---------------------------------------------------------------------------
  // Group-two pending register
  // ---------------------------------------------------------------------------
  logic [7:0] pending_r;
  logic [7:0] pending_nxt;
  logic [7:0] hwSet;
  logic [7:0] swSet;
  logic [7:0] swClr;

  // Request bit placement
  always_comb begin
    hwSet                    = 8'h00;
    hwSet[BIT_PWM_TIMER]     = grp2Req.pwmTimer; // see (R6)
    hwSet[BIT_UART1_RX]      = grp2Req.uart1Rx;
    hwSet[BIT_UART1_TX]      = grp2Req.uart1Tx;
    hwSet[BIT_PWM_FAULT]     = grp2Req.pwmFault;
    hwSet[BIT_PORTC_TOP:0]   = grp2Req.portcOrDma; // see (R7)
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    swSet       = (wrAccess && hitSet) ? wrByte : 8'h00; // see (R5)
    swClr       = (wrAccess && hitPending) ? wrByte : 8'h00; // see (R4)
    pending_nxt = (pending_r & ~swClr) | hwSet | swSet; // see (R1)
  end

  // Sticky pending bits, no enable gating
  always_ff @(posedge core_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      pending_r <= RST_G2_PEND;
    end else begin
      pending_r <= pending_nxt; // see (R11)
    end
  end

  assign grp2Pending = pending_r;

  // ---------------------------------------------------------------------------
  // Forwarding mask and global enable
  // ---------------------------------------------------------------------------
  logic [7:0] mask_r;
  logic       globEn_r;

  // Mask of the pending layout
  always_ff @(posedge core_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      mask_r <= RST_G2_MASK;
    end else if (wrAccess && hitMask) begin
      mask_r <= wrByte;
    end
  end

  // Global enable selects vectored or polled operation
  always_ff @(posedge core_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      globEn_r <= RST_GLOB_EN;
    end else if (wrAccess && hitCtrl) begin
      globEn_r <= wrByte[CTRL_GLOB_EN];
    end
  end

  // Level request while global enable is on and an unmasked bit is pending
  always_ff @(posedge core_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      cpuIrq <= 1'b0;
    end else begin
      cpuIrq <= globEn_r && |(pending_nxt & mask_r); // see (R2) see (R3)
    end
  end

  // ---------------------------------------------------------------------------
  // Read data and error
  // ---------------------------------------------------------------------------
  logic [7:0] rdByte;

  // Read mux, set register reads as zero
  always_comb begin
    rdByte = 8'h00;
    if (hitPrioHigh) begin
      rdByte = prioHigh_r;
    end else if (hitPrioLow) begin
      rdByte = prioLow_r;
    end else if (hitPending) begin
      rdByte = pending_nxt; // see (R3)
    end else if (hitMask) begin
      rdByte = mask_r;
    end else if (hitCtrl) begin
      rdByte = {7'h00, globEn_r};
    end
  end

  // Captured in setup, presented in access
  always_ff @(posedge core_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata  <= pwrite ? 32'h00000000 : {24'h000000, rdByte}; // see (R5)
      pslverr <= !hitAny;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Checks run on the synchronised reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstSync_r);

  a_hw_set_hold: assert property ( // see (R1)
    (grp2Req.pwmTimer && !(wrAccess && hitPending)) ##1 !(wrAccess && hitPending)
      |-> pending_r[BIT_PWM_TIMER] ##1 pending_r[BIT_PWM_TIMER])
    else $error("pending bit not set or not held");

  a_vector_fwd: assert property ( // see (R2)
    (globEn_r && |(pending_r & mask_r) && !(wrAccess && (hitPending || hitMask || hitCtrl)))
      |=> cpuIrq)
    else $error("pending unmasked request not forwarded");

  a_polled_quiet: assert property ( // see (R3)
    !$past(globEn_r) |-> !cpuIrq)
    else $error("interrupt raised in polled operation");

  a_w1c_clear: assert property ( // see (R4)
    (wrAccess && hitPending && hwSet == 8'h00)
      |=> (pending_r & $past(wrByte)) == 8'h00
          && (pending_r & ~$past(wrByte)) == ($past(pending_r) & ~$past(wrByte)))
    else $error("write one to clear misbehaved");

  a_set_reg: assert property ( // see (R5)
    (wrAccess && hitSet) |=> (pending_r & $past(wrByte)) == $past(wrByte))
    else $error("set register did not set pending bits");

  a_set_rdzero: assert property ( // see (R5)
    (setupPhase && !pwrite && hitSet) ##1 (accessPhase && pready) |-> prdata == 32'h00000000)
    else $error("set register read returned data");

  a_portc_map: assert property ( // see (R7)
    (grp2Req.portcOrDma[0] && grp2Req.pwmFault) |=> pending_r[0] && pending_r[BIT_PWM_FAULT])
    else $error("request bit placement wrong");

  a_prio_write: assert property ( // see (R9)
    (wrAccess && hitPrioHigh) |=> ##1 grp0Prio.timer2[1] == $past(wrByte[BIT_TIMER2], 2))
    else $error("enable-high write not reflected");

  a_timer1_level: assert property ( // see (R12)
    (wrAccess && hitPrioHigh && wrByte[BIT_TIMER1] && !wrByte[BIT_TIMER0])
      |=> grp0Prio.timer1[1] && !grp0Prio.timer0[1])
    else $error("timer 1 high enable misplaced");

  a_level_code: assert property ( // see (R8)
    (wrAccess && hitPrioLow && wrByte[BIT_ADC] && !prioHigh_r[BIT_ADC] && !hitPrioHigh)
      |=> grp0Prio.converter == LVL_LOW)
    else $error("level code wrong");

  // ---------------------------------------------------------------------------
  // Checks: request capture, clearing and forwarding
  // ---------------------------------------------------------------------------
  // A clear touches only the bits written with one
  a_pend_sticky: assert property ( // see (R1)
    (pending_r & ~swClr) != 8'h00
      |=> (pending_r & $past(pending_r) & ~$past(swClr))
          == ($past(pending_r) & ~$past(swClr)))
    else $error("pending bit lost without a clear");

  a_hw_any_bit: assert property ( // see (R11)
    (hwSet != 8'h00) |=> (pending_r & $past(hwSet)) == $past(hwSet))
    else $error("hardware request did not set its bit");

  a_uart_tx_bit: assert property ( // see (R6)
    grp2Req.uart1Tx |=> pending_r[BIT_UART1_TX])
    else $error("transmit request in wrong bit");

  a_portc_top: assert property ( // see (R7)
    grp2Req.portcOrDma[3] |=> pending_r[BIT_PORTC_TOP])
    else $error("port C request three in wrong bit");

  // Forwarding needs the global enable and a mask bit one cycle earlier
  a_irq_gated: assert property ( // see (R2)
    cpuIrq |-> $past(globEn_r) && $past(mask_r) != 8'h00)
    else $error("interrupt without enable or mask");

  // ---------------------------------------------------------------------------
  // Checks: bus reads and priority enables
  // ---------------------------------------------------------------------------
  a_rd_pending: assert property ( // see (R3)
    (setupPhase && !pwrite && hitPending) |=> prdata == {24'h000000, pending_r})
    else $error("pending read differs from register");

  a_strb_ignored: assert property ( // see (R9)
    (accessPhase && pwrite && !pstrb[0] && hitPrioHigh) |=> $stable(prioHigh_r))
    else $error("write without byte strobe took effect");

  a_prio_low_write: assert property ( // see (R10)
    (wrAccess && hitPrioLow) |=> grp0Prio.converter[0] == $past(wrByte[BIT_ADC]))
    else $error("enable-low write not reflected");

endmodule // irqpe_top

/* File: verification/irqpe_src_model.sv */
// Peripheral request source model for the group-two pending logic.
// Assumes the bench asks for request pulses synchronous to core_clk.
`timescale 1ns/1ps

module irqpe_src_model
  import irqpe_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] pulseReq,
  output irqpe_req_s      grp2Req
);
  // ---------------------------------------------------------------------------
  // Request pulses
  // ---------------------------------------------------------------------------
  // Registered one-cycle pulses, quiet during reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      grp2Req <= '0;
    end else begin
      grp2Req <= pulseReq;
    end
  end
endmodule // irqpe_src_model

/* File: verification/tb_irq_pending_and_priority_enable.sv */
// Self-checking bench for the pending, set and priority enable registers.
// Assumes an APB slave with zero wait states and a single core clock.
`timescale 1ns/1ps

module tb_irq_pending_and_priority_enable
  import irqpe_pkg::*;
;
  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  irqpe_req_s  grp2Req;
  logic        cpuIrq;
  logic [7:0]  grp2Pending;
  irqpe_prio_s grp0Prio;
  logic [7:0]  pulseReq;
  logic [31:0] rdVal;
  logic        errVal;
  int          fails;
  int          totalChecks;
  int          cycles;

  // Enable patterns that give every level code, converter at low level
  localparam logic [7:0] HI_EXP = 8'hCC;
  localparam logic [7:0] LO_EXP = 8'h55;

  irqpe_top irqpe_top_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .grp2Req(grp2Req),
    .cpuIrq(cpuIrq), .grp2Pending(grp2Pending), .grp0Prio(grp0Prio));

  irqpe_src_model irqpe_src_model_inst (.core_clk(core_clk), .rst_n(rst_n),
    .pulseReq(pulseReq), .grp2Req(grp2Req));

  // ---------------------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------------------
  always #25 core_clk = ~core_clk;

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer: setup, access until pready
  task automatic apb(input logic wr, input logic [29:0] idx, input logic [7:0] wd,
                     input logic [3:0] st);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    pstrb   <= st;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdVal  = prdata;
    errVal = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [29:0] idx, input logic [7:0] wd, input logic [3:0] st);
    apb(1'b1, idx, wd, st);
  endtask

  task automatic rd(input logic [29:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, 4'hF);
    chk(rdVal, exp);
    chk({31'h0, errVal}, 32'h0);
  endtask

  // Bounded wait for the interrupt level
  task automatic wait_irq(input logic exp);
    for (int k = 0; k < 4 && cpuIrq !== exp; k++) @(posedge core_clk);
    #1;
    chk({31'h0, cpuIrq}, {31'h0, exp});
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pulseReq = 8'h00;
    fails = 0;
    totalChecks = 0;
    cycles = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    // Reset values
    rd(IDX_G0_PRIO_HIGH, 32'h0);
    rd(IDX_G0_PRIO_LOW, 32'h0);
    rd(IDX_G2_PENDING, 32'h0);
    // All four level codes, strobe-less write ignored
    wr(IDX_G0_PRIO_HIGH, HI_EXP, 4'hF);
    wr(IDX_G0_PRIO_LOW, LO_EXP, 4'hF);
    wr(IDX_G0_PRIO_HIGH, 8'h00, 4'hE);
    rd(IDX_G0_PRIO_HIGH, {24'h0, HI_EXP});
    rd(IDX_G0_PRIO_LOW, {24'h0, LO_EXP});
    for (int i = 0; i < 8; i++) begin
      chk({30'h0, grp0Prio[2*i+:2]}, {30'h0, HI_EXP[i], LO_EXP[i]});
    end
    // Each source alone, polled, then cleared
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      pulseReq <= 8'h01 << i;
      @(posedge core_clk);
      pulseReq <= 8'h00;
      repeat (2) @(posedge core_clk);
      #1;
      chk({24'h0, grp2Pending}, 32'h1 << i);
      chk({31'h0, cpuIrq}, 32'h0);
      rd(IDX_G2_PENDING, 32'h1 << i);
      wr(IDX_G2_PENDING, 8'h01 << i, 4'hF);
      rd(IDX_G2_PENDING, 32'h0);
    end
    // Fault and port C line zero in one cycle
    @(posedge core_clk);
    pulseReq <= 8'h11;
    @(posedge core_clk);
    pulseReq <= 8'h00;
    repeat (2) @(posedge core_clk);
    #1;
    chk({24'h0, grp2Pending}, 32'h11);
    wr(IDX_G2_PENDING, 8'h11, 4'hF);
    rd(IDX_G2_PENDING, 32'h0);
    // Set register and partial clear
    wr(IDX_G2_SET, 8'hFF, 4'hF);
    rd(IDX_G2_SET, 32'h0);
    wr(IDX_G2_PENDING, 8'h0F, 4'hF);
    rd(IDX_G2_PENDING, 32'hF0);
    // Forwarding under global enable and mask
    wr(IDX_G2_MASK, 8'h80, 4'hF);
    wait_irq(1'b0);
    wr(IDX_CTRL, 8'h01, 4'hF);
    wait_irq(1'b1);
    wr(IDX_G2_MASK, 8'h00, 4'hF);
    wait_irq(1'b0);
    wr(IDX_G2_MASK, 8'h80, 4'hF);
    wait_irq(1'b1);
    wr(IDX_G2_PENDING, 8'h80, 4'hF);
    wait_irq(1'b0);
    rd(IDX_G2_PENDING, 32'h70);
    // Unmapped address
    apb(1'b0, 30'h00000040, 8'h00, 4'hF);
    chk({31'h0, errVal}, 32'h1);
    chk(rdVal, 32'h0);
    finish_test();
  end
endmodule // tb_irq_pending_and_priority_enable
